// file: src/oam_seq_pkg.sv
// Purpose: Shared constants, register map and carriers for the OAM endpoint slice.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package oam_seq_pkg;
	localparam int NGEN = 8;
	localparam logic [15:0] ETYPE_SEQ = 16'h8880;
	localparam logic [15:0] PROTO_ID_SEQ = 16'h0008;
	localparam logic [15:0] MIN_OFS_ETH = 16'h0002;
	localparam logic [15:0] MIN_OFS_UDP = 16'h0008;
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_GEN_CFG = 12'h004;
	localparam logic [11:0] A_COPY_CFG = 12'h008;
	localparam logic [11:0] A_SEQ_CFG = 12'h00C;
	localparam logic [11:0] A_STICKY = 12'h010;
	localparam logic [11:0] A_TX_SEQ = 12'h014;
	localparam logic [11:0] A_RX_SEQ = 12'h018;
	localparam logic [11:0] A_ERR_CNT = 12'h01C;
	localparam logic [11:0] A_RX_CNT = 12'h020;
	localparam logic [11:0] A_TX_CNT = 12'h024;
	localparam logic [11:0] A_OAM_CNT = 12'h028;
	localparam logic [11:0] A_DATA_CNT = 12'h02C;
	// Sticky bit positions above the generic mask field.
	localparam int ST_UNK = 8;
	localparam int ST_LTM = 9;
	localparam int ST_LTR = 10;
	localparam int ST_SEQ = 11;
	localparam int ST_ERR = 12;
	typedef enum logic [2:0] {PDU_DATA, PDU_GENERIC, PDU_UNKNOWN, PDU_LTM, PDU_LTR,
		PDU_SEQ} pdu_class_t;
	typedef enum logic [1:0] {SEQ_OFF, SEQ_MSG, SEQ_RSP} seq_kind_t;
	// Frame descriptor handed in by the lookup pipeline.
	typedef struct packed {
		logic valid;
		logic rx;
		pdu_class_t cls;
		logic [2:0] gen_type;
		logic mel_ok;
		logic dmac_ok;
		logic is_udp;
		logic eth_ep;
		logic [15:0] seq_ofs;
		logic [31:0] seq_no;
		logic fwd_err;
		logic [15:0] comp;
	} frame_in_t;
	// Verdict returned to the pipeline.
	typedef struct packed {
		logic valid;
		logic pass;
		logic copy;
		logic [3:0] queue;
		logic loop;
		logic modify;
		logic [31:0] seq_no;
		logic fwd_err;
		logic [15:0] comp;
	} frame_out_t;
endpackage

// file: src/oam_endpoint_engine.sv
// Purpose: Generic/unknown opcode, link-trace and sequence numbering slice of one endpoint.
// Assumes: One descriptor per cycle at most; verdict one cycle later from flip-flops.
// Notes: Registers over APB; zero wait states.
// Operation
// RULE1: OAM counters gated by generic mask or enable.
// RULE2: Loss data counters gated by masks likewise.
// RULE3: Terminate own-level PDUs unless pass enabled.
// RULE4: Transmit lookup leaves generic/unknown PDUs alone.
// RULE5: Received generic/unknown PDUs set sticky bits.
// RULE6: Copy generic/unknown to their configured queues.
// RULE7: Link trace validated by level and MAC.
// RULE8: Link trace copy and counting, separate enables.
// RULE9: Valid link-trace message/reply set stickies.
// RULE10: Ethernet 0x8880/0x0008 or UDP frames accepted.
// RULE11: Only classifier-marked sequence frames are processed.
// RULE12: Sequence mode excludes test/loopback handling.
// RULE13: Same for all facings; Ethernet endpoints only.
// RULE14: UDP checksum is not checked first.
// RULE15: Message/response from role and direction only.
// RULE16: Responder checks, flags error, loops, copies.
// RULE17: Initiator validates responses, counts, then copies.
// RULE18: Dual-ended: both initiators check received frames.
// RULE19: Sequence offset 16 bits with minimum values.
// RULE20: Field: seq32, error bit, 15 reserved, comp16.
// RULE21: Injector zeroes sequence, error flag, reserved bits.
// RULE22: UDP compensation word keeps checksum unchanged.
// RULE23: Initiator inserts stored number then increments.
// RULE24: Checker compares with previous plus one.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module oam_endpoint_engine
	import oam_seq_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Frame lookup
	input wire frame_in_t FRAME_IN,
	output frame_out_t FRAME_OUT
);
	// One's complement 16-bit add, used for checksum neutral compensation.
	function automatic logic [15:0] ocadd(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// Sum of the 16-bit words covered by the field, excluding the compensation word.
	function automatic logic [15:0] fsum(input logic [31:0] sq, input logic fe);
		return ocadd(ocadd(sq[31:16], sq[15:0]), {fe, 15'h0000});
	endfunction

	logic [31:0] ctrl_q, ctrl_d, gen_q, gen_d, copy_q, copy_d, seqc_q, seqc_d;
	logic [12:0] sticky_q, sticky_d;
	logic [31:0] txseq_q, txseq_d, rxseq_q, rxseq_d, err_q, err_d;
	logic [31:0] rxcnt_q, rxcnt_d, txcnt_q, txcnt_d, oam_q, oam_d, data_q, data_d;
	logic [31:0] prdata_d;
	logic pslverr_d;
	frame_out_t out_q, out_d;

	// ctrl: [7:0] generic pass, [15:8] generic oam count mask, [16] unknown oam count,
	// [24:17] generic data count mask, [25] unknown data count, [26..29] LTM/LTR oam, data.
	// copy: [7:0] generic copy mask, [8] unknown, [9] LTM, [10] LTR, [11] seq copy,
	// [15:12] generic queue, [19:16] default queue, [23:20] link-trace queue,
	// [27:24] seq queue, [28] seq error-only copy.
	// seqc: [0] initiator, [1] responder, [2] loop, [3] err count enable,
	// [4] update checksum, [31:16] offset.
	wire [7:0] gen_pass = ctrl_q[7:0];
	wire [7:0] gen_oam_m = ctrl_q[15:8];
	wire unk_oam_en = ctrl_q[16];
	wire [7:0] gen_data_m = ctrl_q[24:17];
	wire unk_data_en = ctrl_q[25];
	wire seq_init = seqc_q[0];
	wire seq_resp = seqc_q[1] & ~seqc_q[0]; // RULE15
	wire seq_en = seq_init | seq_resp; // RULE12
	wire [15:0] seq_ofs_cfg = seqc_q[31:16];

	wire apb_wr = PSEL & PENABLE & PWRITE;
	// Reads are decoded in the setup cycle, so the registered data already stands when the
	// access phase is sampled; this is what keeps the slave at zero wait states.
	wire apb_rd = PSEL & ~PENABLE & ~PWRITE;
	logic known;

	always_comb begin
		unique case (PADDR)
			A_CTRL, A_GEN_CFG, A_COPY_CFG, A_SEQ_CFG, A_STICKY, A_TX_SEQ, A_RX_SEQ,
			A_ERR_CNT, A_RX_CNT, A_TX_CNT, A_OAM_CNT, A_DATA_CNT: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// Frame evaluation.
	seq_kind_t kind;
	logic rx_v, tx_v, gmask_oam, gmask_data, ofs_ok, seq_bad, cnt_oam, cnt_data;
	logic [31:0] ins_seq;
	logic ins_err;
	always_comb begin
		frame_in_t f;
		f = FRAME_IN;
		rx_v = f.valid & f.rx;
		tx_v = f.valid & ~f.rx;
		gmask_oam = gen_oam_m[f.gen_type];
		gmask_data = gen_data_m[f.gen_type];
		// Sequence mode shares the test/loopback resources and exists only on Ethernet
		// endpoints, so the class is decided purely by role and direction.
		kind = SEQ_OFF;
		if (f.valid && f.cls == PDU_SEQ && seq_en && f.eth_ep && f.dmac_ok) begin // RULE11 RULE13
			kind = ((seq_init && !f.rx) || (seq_resp && f.rx)) ? SEQ_MSG : SEQ_RSP; // RULE15
		end
		ofs_ok = f.is_udp ? (seq_ofs_cfg >= MIN_OFS_UDP) : (seq_ofs_cfg >= MIN_OFS_ETH); // RULE19 RULE10
		seq_bad = (f.seq_no != rxseq_q + 32'h0000_0001); // RULE24
		ins_seq = f.seq_no;
		ins_err = f.fwd_err;
		cnt_oam = 1'b0;
		cnt_data = 1'b0;
		out_d = '0;
		out_d.valid = f.valid;
		out_d.seq_no = f.seq_no;
		out_d.fwd_err = f.fwd_err;
		out_d.comp = f.comp;
		out_d.pass = 1'b1;
		unique case (f.cls)
			PDU_GENERIC, PDU_UNKNOWN: begin
				// Own-level PDUs are terminated both ways unless the type passes.
				if (f.mel_ok)
					out_d.pass = (f.cls == PDU_GENERIC) && gen_pass[f.gen_type]; // RULE3
				cnt_oam = (f.cls == PDU_GENERIC) ? gmask_oam : unk_oam_en; // RULE1
				cnt_data = (f.cls == PDU_GENERIC) ? gmask_data : unk_data_en; // RULE2
				if (rx_v && f.mel_ok) begin // RULE4
					out_d.copy = (f.cls == PDU_GENERIC) ? copy_q[f.gen_type] : copy_q[8]; // RULE6
					out_d.queue = (f.cls == PDU_GENERIC) ? copy_q[15:12] : copy_q[19:16]; // RULE6
				end
			end
			PDU_LTM, PDU_LTR: begin
				if (f.mel_ok && f.dmac_ok) begin // RULE7
					out_d.pass = 1'b0;
					cnt_oam = (f.cls == PDU_LTM) ? ctrl_q[26] : ctrl_q[27]; // RULE8
					cnt_data = (f.cls == PDU_LTM) ? ctrl_q[28] : ctrl_q[29]; // RULE8
					if (rx_v) begin
						out_d.copy = (f.cls == PDU_LTM) ? copy_q[9] : copy_q[10]; // RULE8
						out_d.queue = copy_q[23:20]; // RULE8
					end
				end
			end
			default: ;
		endcase
		if (kind != SEQ_OFF && ofs_ok) begin
			out_d.queue = copy_q[27:24];
			if (tx_v && kind == SEQ_MSG) begin
				ins_seq = txseq_q; // RULE23
				out_d.seq_no = ins_seq;
				out_d.modify = 1'b1;
			end else if (rx_v) begin
				out_d.copy = copy_q[11] | (copy_q[28] & seq_bad); // RULE16 RULE17 RULE18
				if (kind == SEQ_MSG && seq_resp) begin
					ins_err = f.fwd_err | seq_bad; // RULE16
					out_d.fwd_err = ins_err;
					out_d.modify = seq_bad;
					out_d.loop = seqc_q[2]; // RULE16
				end
			end
			// Checksum is not verified; the compensation absorbs the field change.
			if (out_d.modify && f.is_udp && seqc_q[4]) // RULE14 RULE22
				out_d.comp = ~ocadd(ocadd(~f.comp, fsum(f.seq_no, f.fwd_err)),
					~fsum(ins_seq, ins_err)); // RULE20 RULE21
		end
	end

	// Register next values.
	always_comb begin
		ctrl_d = ctrl_q;
		gen_d = gen_q;
		copy_d = copy_q;
		seqc_d = seqc_q;
		sticky_d = sticky_q;
		txseq_d = txseq_q;
		rxseq_d = rxseq_q;
		err_d = err_q;
		rxcnt_d = rxcnt_q;
		txcnt_d = txcnt_q;
		oam_d = oam_q;
		data_d = data_q;
		if (apb_wr) begin
			unique case (PADDR)
				A_CTRL: ctrl_d = PWDATA;
				A_GEN_CFG: gen_d = PWDATA;
				A_COPY_CFG: copy_d = PWDATA;
				A_SEQ_CFG: seqc_d = PWDATA;
				A_STICKY: sticky_d = sticky_q & ~PWDATA[12:0];
				A_TX_SEQ: txseq_d = PWDATA;
				A_RX_SEQ: rxseq_d = PWDATA;
				A_ERR_CNT: err_d = PWDATA;
				A_RX_CNT: rxcnt_d = PWDATA;
				A_TX_CNT: txcnt_d = PWDATA;
				A_OAM_CNT: oam_d = PWDATA;
				A_DATA_CNT: data_d = PWDATA;
				default: ;
			endcase
		end
		// Hardware events come after the bus write so a set wins over a clear.
		// Idle descriptors carry stale fields, so only a valid one may count.
		if (cnt_oam && FRAME_IN.valid)
			oam_d = oam_q + 32'h0000_0001; // RULE1 RULE8
		if (cnt_data && FRAME_IN.valid)
			data_d = data_q + 32'h0000_0001; // RULE2 RULE8
		if (rx_v && FRAME_IN.mel_ok) begin
			if (FRAME_IN.cls == PDU_GENERIC)
				sticky_d[FRAME_IN.gen_type] = 1'b1; // RULE5
			if (FRAME_IN.cls == PDU_UNKNOWN)
				sticky_d[ST_UNK] = 1'b1; // RULE5
			if (FRAME_IN.dmac_ok && FRAME_IN.cls == PDU_LTM)
				sticky_d[ST_LTM] = 1'b1; // RULE9
			if (FRAME_IN.dmac_ok && FRAME_IN.cls == PDU_LTR)
				sticky_d[ST_LTR] = 1'b1; // RULE9
		end
		if (kind != SEQ_OFF && ofs_ok) begin
			if (tx_v && kind == SEQ_MSG)
				txseq_d = txseq_q + 32'h0000_0001; // RULE23
			if (tx_v && kind == SEQ_RSP)
				txcnt_d = txcnt_q + 32'h0000_0001;
			if (rx_v) begin
				sticky_d[ST_SEQ] = 1'b1;
				rxcnt_d = rxcnt_q + 32'h0000_0001;
				rxseq_d = FRAME_IN.seq_no; // RULE24
				if (seq_bad && (seq_resp || seqc_q[3])) begin // RULE17
					err_d = err_q + 32'h0000_0001; // RULE24
					sticky_d[ST_ERR] = 1'b1; // RULE24
				end
			end
		end
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (apb_rd) begin
			unique case (PADDR)
				A_CTRL: prdata_d = ctrl_q;
				A_GEN_CFG: prdata_d = gen_q;
				A_COPY_CFG: prdata_d = copy_q;
				A_SEQ_CFG: prdata_d = seqc_q;
				A_STICKY: prdata_d = {19'h00000, sticky_q};
				A_TX_SEQ: prdata_d = txseq_q;
				A_RX_SEQ: prdata_d = rxseq_q;
				A_ERR_CNT: prdata_d = err_q;
				A_RX_CNT: prdata_d = rxcnt_q;
				A_TX_CNT: prdata_d = txcnt_q;
				A_OAM_CNT: prdata_d = oam_q;
				A_DATA_CNT: prdata_d = data_q;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		if (PSEL && !PENABLE && !known)
			pslverr_d = 1'b1;
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q <= '0;
			gen_q <= '0;
			copy_q <= '0;
			seqc_q <= 32'h0002_0000;
			sticky_q <= '0;
			txseq_q <= '0;
			rxseq_q <= '0;
			err_q <= '0;
			rxcnt_q <= '0;
			txcnt_q <= '0;
			oam_q <= '0;
			data_q <= '0;
			out_q <= '0;
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			gen_q <= gen_d;
			copy_q <= copy_d;
			seqc_q <= seqc_d;
			sticky_q <= sticky_d;
			txseq_q <= txseq_d;
			rxseq_q <= rxseq_d;
			err_q <= err_d;
			rxcnt_q <= rxcnt_d;
			txcnt_q <= txcnt_d;
			oam_q <= oam_d;
			data_q <= data_d;
			out_q <= out_d;
			PRDATA <= prdata_d;
			PREADY <= 1'b1;
			PSLVERR <= pslverr_d;
		end
	end

	assign FRAME_OUT = out_q;

	property p_seq_inc;
		@(posedge CLOCK) disable iff (RST)
		(tx_v && kind == SEQ_MSG && ofs_ok && !apb_wr) |=> (txseq_q == $past(txseq_q) + 1);
	endproperty
	a_seq_inc: assert property (p_seq_inc) else $error("tx sequence not incremented"); // RULE23

	property p_ins;
		@(posedge CLOCK) disable iff (RST)
		(tx_v && kind == SEQ_MSG && ofs_ok) |=> (FRAME_OUT.seq_no == $past(txseq_q));
	endproperty
	a_ins: assert property (p_ins) else $error("stored sequence not inserted"); // RULE23

	property p_err;
		@(posedge CLOCK) disable iff (RST)
		(rx_v && kind != SEQ_OFF && ofs_ok && seq_bad && seq_resp) |=> sticky_q[ST_ERR];
	endproperty
	a_err: assert property (p_err) else $error("error sticky not set"); // RULE24

	property p_fwd;
		@(posedge CLOCK) disable iff (RST)
		(rx_v && kind == SEQ_MSG && seq_resp && ofs_ok && seq_bad) |=> FRAME_OUT.fwd_err;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward error flag missing"); // RULE16

	property p_tx_generic;
		@(posedge CLOCK) disable iff (RST)
		(tx_v && FRAME_IN.cls inside {PDU_GENERIC, PDU_UNKNOWN})
			|=> !FRAME_OUT.copy && !FRAME_OUT.modify;
	endproperty
	a_tx_generic: assert property (p_tx_generic) else $error("tx generic acted on"); // RULE4

	property p_unk_sticky;
		@(posedge CLOCK) disable iff (RST)
		(rx_v && FRAME_IN.mel_ok && FRAME_IN.cls == PDU_UNKNOWN) |=> sticky_q[ST_UNK];
	endproperty
	a_unk_sticky: assert property (p_unk_sticky) else $error("unknown sticky not set"); // RULE5

	property p_ltm;
		@(posedge CLOCK) disable iff (RST)
		(rx_v && FRAME_IN.cls == PDU_LTM && !FRAME_IN.dmac_ok) |=> !FRAME_OUT.copy;
	endproperty
	a_ltm: assert property (p_ltm) else $error("invalid link trace copied"); // RULE7

	property p_terminate;
		@(posedge CLOCK) disable iff (RST)
		(FRAME_IN.valid && FRAME_IN.mel_ok && FRAME_IN.cls == PDU_UNKNOWN) |=> !FRAME_OUT.pass;
	endproperty
	a_terminate: assert property (p_terminate) else $error("own level unknown passed"); // RULE3

	property p_rxstore;
		@(posedge CLOCK) disable iff (RST)
		(rx_v && kind != SEQ_OFF && ofs_ok && !apb_wr) |=> (rxseq_q == $past(FRAME_IN.seq_no));
	endproperty
	a_rxstore: assert property (p_rxstore) else $error("received number not stored"); // RULE24
endmodule
`default_nettype wire

// file: test/peer_endpoint_model.sv
// Purpose: Peer endpoint that sends numbered frames and OAM PDUs into the Rx lookup.
// Assumes: A frame appears the cycle after SEND and stands for one cycle.
// Notes: Between frames the fields flip to the inverse of their previous value each cycle, so stale data shows.
`timescale 1ns/1ps
`default_nettype none
module peer_endpoint_model
	import oam_seq_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Requests from the bench
	input wire logic SEND,
	input wire logic SKIP,
	input wire pdu_class_t KIND,
	input wire logic [2:0] GEN,
	input wire logic DMAC_OK,
	// Frame towards the endpoint
	output frame_in_t LINK_OUT
);
	logic [31:0] next_q;
	logic [31:0] next_d;
	frame_in_t out_q;
	frame_in_t out_d;
	always_comb begin
		next_d = next_q;
		out_d = ~out_q;
		out_d.valid = 1'b0;
		if (SEND) begin
			out_d = '0;
			out_d.valid = 1'b1;
			out_d.rx = 1'b1;
			out_d.cls = KIND;
			out_d.gen_type = GEN;
			out_d.mel_ok = 1'b1;
			out_d.dmac_ok = DMAC_OK;
			out_d.eth_ep = 1'b1;
			out_d.seq_ofs = MIN_OFS_ETH;
			if (KIND == PDU_SEQ) begin
				// SKIP drops one number, as a frame lost on the way would.
				out_d.seq_no = next_q + {31'h0, SKIP};
				next_d = out_d.seq_no + 32'h1;
			end
		end
	end
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			next_q <= 32'h1;
			out_q <= '0;
		end else begin
			next_q <= next_d;
			out_q <= out_d;
		end
	end
	assign LINK_OUT = out_q;
endmodule
`default_nettype wire

// file: test/oam_endpoint_engine_tb.sv
// Purpose: Self-checking bench for the endpoint slice.
// Assumes: Zero-wait APB slave; verdict one cycle after a descriptor.
// Notes: Tx descriptors come from the bench, Rx ones from the peer model.
`timescale 1ns/1ps
`default_nettype none
module oam_endpoint_engine_tb
	import oam_seq_pkg::*;
;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, send, skip, dmac;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] gen;
	pdu_class_t kind;
	frame_in_t tb_f, peer_f, frame_in;
	frame_out_t frame_out, o, o2;
	int mismatches = 0;
	int n_compared = 0;
	assign frame_in = tb_f.valid ? tb_f : peer_f;
	always #10 clock = ~clock;
	oam_endpoint_engine dut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FRAME_IN(frame_in), .FRAME_OUT(frame_out));
	peer_endpoint_model peer (.CLOCK(clock), .RST(rst), .SEND(send), .SKIP(skip), .KIND(kind),
		.GEN(gen), .DMAC_OK(dmac), .LINK_OUT(peer_f));
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			stop_test;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// Valid, pass, copy, loop, modify and the queue, which only counts when copying.
	function automatic logic [31:0] vd(input frame_out_t f);
		vd = {23'h0, f.valid, f.pass, f.copy, f.loop, f.modify, f.queue & {4{f.copy}}};
	endfunction
	// One's-complement sum of the words that the endpoint may rewrite.
	function automatic logic [15:0] fold(input logic [31:0] s, input logic e, input logic [15:0] c);
		logic [17:0] t;
		t = {2'h0, s[31:16]} + {2'h0, s[15:0]} + {2'h0, e, 15'h0} + {2'h0, c};
		t = {2'h0, t[15:0]} + {16'h0, t[17:16]};
		t = {2'h0, t[15:0]} + {16'h0, t[17:16]};
		fold = (t[15:0] == 16'hFFFF) ? 16'h0 : t[15:0];
	endfunction
	task automatic rxf(input pdu_class_t k, input logic [2:0] g, input logic sk, input logic dm);
		@(posedge clock);
		send <= 1'b1;
		kind <= k;
		gen <= g;
		skip <= sk;
		dmac <= dm;
		@(posedge clock);
		send <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		o = frame_out;
	endtask
	task automatic txf(input frame_in_t f);
		@(posedge clock);
		tb_f <= f;
		@(posedge clock);
		tb_f <= '0;
		@(negedge clock);
		o = frame_out;
	endtask
	task automatic t_regs;
		rdc(A_SEQ_CFG, 32'h0002_0000);
		rdc(12'h0FC, 32'h0);
		check({31'h0, pslverr}, 32'h1);
	endtask
	task automatic t_generic;
		apb(1'b1, A_CTRL, 32'h0001_0808);
		apb(1'b1, A_COPY_CFG, 32'h0005_A108);
		rxf(PDU_GENERIC, 3'h3, 1'b0, 1'b1);
		check(vd(o), 32'h1CA);
		rxf(PDU_GENERIC, 3'h2, 1'b0, 1'b1);
		check(vd(o), 32'h100);
		rxf(PDU_UNKNOWN, 3'h0, 1'b0, 1'b1);
		check(vd(o), 32'h145);
		rdc(A_STICKY, 32'h0000_010C);
		rdc(A_OAM_CNT, 32'h2);
		rdc(A_DATA_CNT, 32'h0);
		txf('{1'b1, 1'b0, PDU_GENERIC, 3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 16'h2, 32'h0, 1'b0, 16'h0});
		check(vd(o), 32'h180);
	endtask
	task automatic t_link;
		apb(1'b1, A_STICKY, 32'hFFFF_FFFF);
		apb(1'b1, A_COPY_CFG, 32'h0060_0200);
		apb(1'b1, A_CTRL, 32'h0400_0000);
		apb(1'b1, A_OAM_CNT, 32'h0);
		rxf(PDU_LTM, 3'h0, 1'b0, 1'b1);
		check(vd(o), 32'h146);
		rxf(PDU_LTM, 3'h0, 1'b0, 1'b0);
		check({31'h0, o.copy}, 32'h0);
		rxf(PDU_LTR, 3'h0, 1'b0, 1'b1);
		check({31'h0, o.copy}, 32'h0);
		rdc(A_STICKY, 32'h0000_0600);
		rdc(A_OAM_CNT, 32'h1);
	endtask
	task automatic t_resp;
		apb(1'b1, A_STICKY, 32'hFFFF_FFFF);
		apb(1'b1, A_SEQ_CFG, 32'h0002_0006);
		rxf(PDU_SEQ, 3'h0, 1'b0, 1'b1);
		check({o.seq_no[29:0], o.loop, o.fwd_err}, 32'h6);
		rxf(PDU_SEQ, 3'h0, 1'b1, 1'b1);
		check({o.seq_no[29:0], o.loop, o.fwd_err}, 32'hF);
		rdc(A_ERR_CNT, 32'h1);
		rdc(A_RX_SEQ, 32'h3);
		rdc(A_RX_CNT, 32'h2);
		rdc(A_STICKY, 32'h0000_1800);
	endtask
	task automatic t_irx;
		apb(1'b1, A_STICKY, 32'hFFFF_FFFF);
		apb(1'b1, A_SEQ_CFG, 32'h0002_0009);
		apb(1'b1, A_COPY_CFG, 32'h1300_0000);
		rxf(PDU_SEQ, 3'h0, 1'b0, 1'b1);
		check(vd(o), 32'h180);
		rxf(PDU_SEQ, 3'h0, 1'b1, 1'b1);
		check(vd(o), 32'h1C3);
		check(o.seq_no, 32'h6);
		rdc(A_ERR_CNT, 32'h2);
		rdc(A_RX_SEQ, 32'h6);
		rdc(A_STICKY, 32'h0000_1800);
	endtask
	task automatic t_init;
		frame_in_t f;
		// The injector leaves sequence number, flag and reserved bits at zero.
		f = '{1'b1, 1'b0, PDU_SEQ, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 16'h8, 32'h0, 1'b0, 16'h1234};
		apb(1'b1, A_SEQ_CFG, 32'h0008_0011);
		apb(1'b1, A_TX_SEQ, 32'hFFFF_FFFF);
		@(posedge clock);
		tb_f <= f;
		@(posedge clock);
		@(negedge clock);
		o = frame_out;
		@(posedge clock);
		tb_f <= '0;
		@(negedge clock);
		o2 = frame_out;
		check(o.seq_no, 32'hFFFF_FFFF);
		check(o2.seq_no, 32'h0);
		check({31'h0, o.modify}, 32'h1);
		check({16'h0, fold(o.seq_no, o.fwd_err, o.comp)}, 32'h0000_1234);
		check({16'h0, fold(o2.seq_no, o2.fwd_err, o2.comp)}, 32'h0000_1234);
		f.eth_ep = 1'b0;
		txf(f);
		check({31'h0, o.modify}, 32'h0);
		f.eth_ep = 1'b1;
		f.cls = PDU_DATA;
		txf(f);
		check({31'h0, o.modify}, 32'h0);
		rdc(A_TX_SEQ, 32'h1);
	endtask
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, send, skip, dmac} = '0;
		paddr = 12'h0;
		pwdata = 32'h0;
		gen = 3'h0;
		kind = PDU_DATA;
		tb_f = '0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_generic;
		t_link;
		t_resp;
		t_irx;
		t_init;
		stop_test;
	end
endmodule
`default_nettype wire
